// *** e1pm_top.sv ***
`timescale 1ns/1ns
// E1 receive performance counters and last signaling change flags
module e1pm_top #(
  parameter longint ONE_SEC_CYCLES = e1pm_pkg::SECOND_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [e1pm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [e1pm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Framer event pulses, one cycle each, on mclk
  input wire logic crc4_err_pulse,
  input wire logic framing_err_pulse,
  input wire logic align_shift_pulse,
  input wire logic frame_loss_pulse,
  input wire logic pattern_err_pulse,
  input wire logic bipolar_viol_pulse,
  input wire logic hdb3_viol_pulse,
  input wire logic near_crc_err_pulse,
  input wire logic far_block_err_pulse,
  input wire logic near_far_err_pulse,
  // Extracted signaling word for one timeslot
  input wire logic sig_valid,
  input wire logic [4:0] sig_timeslot,
  input wire logic [3:0] sig_abcd,
  output logic signaling_irq
);
  import e1pm_pkg::*;

  // ****************************************
  // Bus slave state
  // ****************************************
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_byte;
  logic rd_hit;

  // Writes are taken only when address and data are both present
  wire wr_start = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
  wire wr_fire = awready_q && s_axi_awvalid;
  wire [7:0] wr_idx = s_axi_awaddr[IDX_LSB +: 8];
  wire wr_lane0 = wr_fire && s_axi_wstrb[0];
  wire rd_start = s_axi_arvalid && !arready_q && !rvalid_q;
  wire rd_fire = arready_q && s_axi_arvalid;
  wire [7:0] rd_idx = s_axi_araddr[IDX_LSB +: 8];
  wire [ADDR_W-1:0] byte_mask = ADDR_W'(3);
  wire wr_aligned = (s_axi_awaddr & byte_mask) == '0;
  wire rd_aligned = (s_axi_araddr & byte_mask) == '0;

  // ****************************************
  // Software control registers
  // ****************************************
  logic auto_snap_q;
  logic trig_q;
  logic hdb3_mode_q;
  logic sig_irq_en_q;
  logic trig_prev_q;
  wire ctrl_wr = wr_lane0 && wr_aligned && (wr_idx == IDX_SNAP_CTRL);
  wire cfg_wr = wr_lane0 && wr_aligned && (wr_idx == IDX_SIG_CFG);
  wire flag_wr = wr_lane0 && wr_aligned && (wr_idx == IDX_SIG_FLAGS3);

  // Control bits written by software
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      auto_snap_q <= 1'b0;
      trig_q <= 1'b0;
      hdb3_mode_q <= 1'b0;
      sig_irq_en_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        auto_snap_q <= s_axi_wdata[AUTO_BIT];
        trig_q <= s_axi_wdata[TRIG_BIT];
        hdb3_mode_q <= s_axi_wdata[HDB3_BIT];
      end
      if (cfg_wr) begin
        sig_irq_en_q <= s_axi_wdata[IRQ_EN_BIT];
      end
    end
  end

  // ****************************************
  // Snapshot timing
  // ****************************************
  logic [31:0] sec_cnt_q;
  logic sec_tick_q;
  localparam logic [31:0] SEC_LAST = 32'(ONE_SEC_CYCLES - 1);
  wire sec_wrap = (sec_cnt_q == SEC_LAST);

  // One-second divider; free running so the period stays exact
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sec_cnt_q <= '0;
      sec_tick_q <= 1'b0;
    end else begin
      sec_cnt_q <= sec_wrap ? '0 : sec_cnt_q + 32'h1;
      sec_tick_q <= sec_wrap;
    end
  end

  // Trigger bit history for edge detection
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_q;
    end
  end

  // Rewriting a one does not fire again; software must write zero first
  wire trig_rise = trig_q && !trig_prev_q; // see (RL4)
  wire auto_fire = auto_snap_q && sec_tick_q; // see (RL5)
  wire snap = trig_rise || auto_fire; // see (RL4) see (RL5)

  // ****************************************
  // Counters
  // ****************************************
  logic [CRC_W-1:0] crc_snap;
  logic [FRAME_W-1:0] frame_snap;
  logic [SHIFT_W-1:0] shift_snap;
  logic [LOSS_W-1:0] loss_snap;
  logic [PAT_W-1:0] pat_snap;
  logic [VIOL_W-1:0] viol_snap;
  logic [NCRC_W-1:0] ncrc_snap;
  logic [FAR_W-1:0] far_snap;
  logic [NFE_W-1:0] nfe_snap;

  // Only the violation type of the active line code is counted
  wire viol_event = hdb3_mode_q ? hdb3_viol_pulse : bipolar_viol_pulse; // see (RL11)

  e1pm_counter #(.W(CRC_W)) u_crc ( // see (RL6)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(crc4_err_pulse),
    .snap(snap),
    .snapshot_q(crc_snap)
  );
  e1pm_counter #(.W(FRAME_W)) u_frame ( // see (RL7)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(framing_err_pulse),
    .snap(snap),
    .snapshot_q(frame_snap)
  );
  e1pm_counter #(.W(SHIFT_W)) u_shift ( // see (RL8)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(align_shift_pulse),
    .snap(snap),
    .snapshot_q(shift_snap)
  );
  e1pm_counter #(.W(LOSS_W)) u_loss ( // see (RL9)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(frame_loss_pulse),
    .snap(snap),
    .snapshot_q(loss_snap)
  );
  e1pm_counter #(.W(PAT_W)) u_pat ( // see (RL10)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(pattern_err_pulse),
    .snap(snap),
    .snapshot_q(pat_snap)
  );
  e1pm_counter #(.W(VIOL_W)) u_viol ( // see (RL11)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(viol_event),
    .snap(snap),
    .snapshot_q(viol_snap)
  );
  e1pm_counter #(.W(NCRC_W)) u_ncrc ( // see (RL12)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(near_crc_err_pulse),
    .snap(snap),
    .snapshot_q(ncrc_snap)
  );
  e1pm_counter #(.W(FAR_W)) u_far ( // see (RL13)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(far_block_err_pulse),
    .snap(snap),
    .snapshot_q(far_snap)
  );
  e1pm_counter #(.W(NFE_W)) u_nfe ( // see (RL14)
    .mclk(mclk),
    .resetn(resetn),
    .event_pulse(near_far_err_pulse),
    .snap(snap),
    .snapshot_q(nfe_snap)
  );

  // ****************************************
  // Signaling change flags, timeslots 26..31
  // ****************************************
  logic [3:0] last_abcd_q [NUM_FLAGS];
  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  wire [4:0] ts_off = sig_timeslot - FIRST_TS;
  wire ts_in_range = (sig_timeslot >= FIRST_TS);

  // Bit i follows timeslot 26+i; a change against the held word sets it
  always_comb begin
    for (int i = 0; i < NUM_FLAGS; i++) begin
      flag_set[i] = sig_valid && ts_in_range && (ts_off == 5'(i))
                    && (sig_abcd != last_abcd_q[i]); // see (RL1) see (RL3)
      flag_clr[i] = flag_wr && s_axi_wdata[i]; // see (RL2)
    end
  end

  // Held words and sticky flags; a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= '0;
      for (int i = 0; i < NUM_FLAGS; i++) begin
        last_abcd_q[i] <= '0;
      end
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr); // see (RL1) see (RL2)
      for (int i = 0; i < NUM_FLAGS; i++) begin
        if (flag_set[i]) begin
          last_abcd_q[i] <= sig_abcd;
        end
      end
    end
  end

  // Interrupt level follows the flags while enabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      signaling_irq <= 1'b0;
    end else begin
      signaling_irq <= sig_irq_en_q && (|flags_q); // see (RL15)
    end
  end

  // ****************************************
  // Read decode
  // ****************************************
  always_comb begin
    rd_byte = RST_BYTE;
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_CRC_LO: rd_byte = crc_snap[7:0]; // see (RL6)
      IDX_CRC_HI: rd_byte = 8'(crc_snap[CRC_W-1:8]) << HI_POS;
      IDX_FRAME_LO: rd_byte = frame_snap[7:0]; // see (RL7)
      IDX_FRAME_HI: rd_byte = 8'(frame_snap[FRAME_W-1:8]);
      IDX_SHIFT: rd_byte = 8'(shift_snap); // see (RL8)
      IDX_LOSS: rd_byte = 8'(loss_snap); // see (RL9)
      IDX_PAT_LO: rd_byte = pat_snap[7:0]; // see (RL10)
      IDX_PAT_HI: rd_byte = pat_snap[15:8];
      IDX_VIOL_LO: rd_byte = viol_snap[7:0];
      IDX_VIOL_HI: rd_byte = viol_snap[15:8];
      IDX_NCRC_LO: rd_byte = ncrc_snap[7:0]; // see (RL12)
      IDX_NCRC_HI: rd_byte = 8'(ncrc_snap[NCRC_W-1:8]) << HI_POS;
      IDX_FAR_LO: rd_byte = far_snap[7:0]; // see (RL13)
      IDX_FAR_HI: rd_byte = 8'(far_snap[FAR_W-1:8]) << HI_POS;
      IDX_NFE_LO: rd_byte = nfe_snap[7:0]; // see (RL14)
      IDX_NFE_HI: rd_byte = 8'(nfe_snap[NFE_W-1:8]) << HI_POS; // see (RL16)
      IDX_SNAP_CTRL: rd_byte = 8'({hdb3_mode_q, trig_q, auto_snap_q});
      IDX_SIG_CFG: rd_byte = 8'({sig_irq_en_q, 1'b0});
      IDX_SIG_FLAGS3: rd_byte = 8'(flags_q); // see (RL2) see (RL3)
      default: rd_hit = 1'b0;
    endcase
    if (!rd_aligned) begin
      rd_hit = 1'b0;
      rd_byte = RST_BYTE;
    end
  end

  // Write target check; writes to read-only counters are accepted and dropped
  wire wr_hit = wr_aligned && ((wr_idx <= IDX_NFE_HI) || (wr_idx == IDX_SNAP_CTRL)
                || (wr_idx == IDX_SIG_CFG) || (wr_idx == IDX_SIG_FLAGS3));

  // ****************************************
  // Write channel handshake
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      awready_q <= wr_start;
      wready_q <= wr_start;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel handshake
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= rd_start;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// *** e1pm_pkg.sv ***
// Notes on behaviour
// (RL1) A timeslot change flag sets when its received signaling bits change.
// (RL2) Writing one clears a change flag; zero leaves it; reads show it.
// (RL3) Last flag register: bits 5..0 are timeslots 31..26; bits 7..6 reserved.
// (RL4) A zero-to-one step of the snapshot trigger bit refreshes all snapshots.
// (RL5) With auto snapshot enabled, all snapshots refresh once every second.
// (RL6) CRC-4 errors: 10-bit count, bits 7..0 then bits 9..8.
// (RL7) Framing bit or pattern errors: multi-byte count, low byte first.
// (RL8) Alignment position changes: 3-bit count.
// (RL9) Loss of basic frame sync events: 5-bit count in bits 4..0.
// (RL10) Pattern detector bit errors: 16-bit count, low byte then high byte.
// (RL11) Line code violations: bipolar in AMI mode, code violations in HDB3 mode.
// (RL12) Near-end CRC errors: 10-bit count over two registers.
// (RL13) Far end block error indications: 10-bit count over two registers.
// (RL14) Near-end far-end block errors: low eight bits in their own register.
// (RL15) With the change interrupt enabled, interrupt is high while any flag set.
// (RL16) Bits 9..8 of the near-end far-end count sit in the next register.
// (RL17) Snapshot copies all live counts at once and restarts them losslessly.
package e1pm_pkg;
  // ****************************************
  // Register indexes (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] IDX_CRC_LO = 8'h00;
  localparam logic [7:0] IDX_CRC_HI = 8'h01;
  localparam logic [7:0] IDX_FRAME_LO = 8'h02;
  localparam logic [7:0] IDX_FRAME_HI = 8'h03;
  localparam logic [7:0] IDX_SHIFT = 8'h04;
  localparam logic [7:0] IDX_LOSS = 8'h05;
  localparam logic [7:0] IDX_PAT_LO = 8'h06;
  localparam logic [7:0] IDX_PAT_HI = 8'h07;
  localparam logic [7:0] IDX_VIOL_LO = 8'h08;
  localparam logic [7:0] IDX_VIOL_HI = 8'h09;
  localparam logic [7:0] IDX_NCRC_LO = 8'h0A;
  localparam logic [7:0] IDX_NCRC_HI = 8'h0B;
  localparam logic [7:0] IDX_FAR_LO = 8'h0C;
  localparam logic [7:0] IDX_FAR_HI = 8'h0D;
  localparam logic [7:0] IDX_NFE_LO = 8'h0E;
  localparam logic [7:0] IDX_NFE_HI = 8'h0F;
  localparam logic [7:0] IDX_SNAP_CTRL = 8'hC2;
  localparam logic [7:0] IDX_SIG_CFG = 8'hD2;
  localparam logic [7:0] IDX_SIG_FLAGS3 = 8'hD9;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int AUTO_BIT = 0;   // auto_snapshot_each_second
  localparam int TRIG_BIT = 1;   // counter_snapshot_trigger
  localparam int HDB3_BIT = 2;   // 1 = HDB3 decoding, 0 = AMI
  localparam int IRQ_EN_BIT = 1; // signaling_change_irq_enable
  localparam int HI_POS = 4;     // upper two bits of 10-bit counts sit at 5..4
  localparam int NUM_FLAGS = 6;
  localparam logic [4:0] FIRST_TS = 5'h1A;
  localparam int CRC_W = 10;
  localparam int FRAME_W = 12;
  localparam int SHIFT_W = 3;
  localparam int LOSS_W = 5;
  localparam int PAT_W = 16;
  localparam int VIOL_W = 16;
  localparam int NCRC_W = 10;
  localparam int FAR_W = 10;
  localparam int NFE_W = 10;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ****************************************
  // Bus answers and timing
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint SECOND_NS = 1000000000;
  localparam longint SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
endpackage

// *** e1pm_counter.sv ***
`timescale 1ns/1ns
// Live event counter with a snapshot register
module e1pm_counter #(
  parameter int W = 10
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic event_pulse,
  input wire logic snap,
  output logic [W-1:0] snapshot_q
);
  logic [W-1:0] live_q;
  logic [W-1:0] live_d;
  logic [W-1:0] next_count;
  wire at_max = &live_q;

  // Saturate rather than wrap so a stuck error source never reads as few errors
  assign next_count = (event_pulse && !at_max) ? live_q + W'(1) : live_q;
  // Restart at the coincident event so nothing is lost across a snapshot
  assign live_d = snap ? {{(W-1){1'b0}}, event_pulse} : next_count; // see (RL17)

  // Live count and its held copy
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      live_q <= '0;
      snapshot_q <= '0;
    end else begin
      live_q <= live_d;
      if (snap) begin
        snapshot_q <= live_q; // see (RL17)
      end
    end
  end
endmodule

// *** e1pm_top_asserts.sv ***
`timescale 1ns/1ns
// ****************************************
// Bus handshake and interrupt checks
// ****************************************
module e1pm_top_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rready,
  input wire logic sig_valid,
  input wire logic signaling_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Both write channels are taken at one edge
  sequence wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  // Response is held until the master takes it
  sequence resp_waits;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  aw_w_pair_a: assert property (s_axi_awready == s_axi_wready) else $error("write readies differ");
  ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("write ready longer than one cycle");
  wr_resp_a: assert property (wr_taken |=> s_axi_bvalid) else $error("write response late");
  resp_hold_a: assert property (resp_waits |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  no_accept_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken during response");
  rd_latency_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  irq_rise_a: assert property ($rose(signaling_irq) |-> $past(sig_valid, 2) || $past(s_axi_awready, 2))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(signaling_irq) |-> $past(s_axi_awready, 2))
    else $error("interrupt fell without write");
endmodule
bind e1pm_top e1pm_top_asserts e1pm_top_asserts_inst (.mclk, .resetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rready,
  .sig_valid, .signaling_irq);

// *** test_e1pm_top.sv ***
`timescale 1ns/1ns
// ****************************************
// Counter bank and change flag bench
// ****************************************
module test_e1pm_top;
  import e1pm_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [9:0] evq = '0;
  logic sig_valid = 1'b0;
  logic [4:0] sig_ts = '0;
  logic [3:0] sig_abcd = '0;
  int num_errors = 0, n_tests = 0, cyc = 0;
  // Event counts per period: crc, framing, shift, loss, pattern, bipolar, hdb3, near crc, far, near far
  int ecnt [10] = '{32'h2A5, 32'h312, 32'h9, 32'h13, 32'h1F0, 32'h105, 32'h44, 32'h301, 32'h1FF, 32'h2C3};
  // Shift count saturates at 7; high bits of 10-bit counts sit at 5..4
  logic [7:0] exp1 [16] = '{8'hA5, 8'h20, 8'h12, 8'h03, 8'h07, 8'h13, 8'hF0, 8'h01,
                            8'h05, 8'h01, 8'h01, 8'h30, 8'hFF, 8'h10, 8'hC3, 8'h20};
  // Short second so the automatic refresh is seen within the run
  e1pm_top #(.ONE_SEC_CYCLES(300)) e1pm_top_inst (.mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .crc4_err_pulse(evq[0]), .framing_err_pulse(evq[1]), .align_shift_pulse(evq[2]),
    .frame_loss_pulse(evq[3]), .pattern_err_pulse(evq[4]), .bipolar_viol_pulse(evq[5]),
    .hdb3_viol_pulse(evq[6]), .near_crc_err_pulse(evq[7]), .far_block_err_pulse(evq[8]),
    .near_far_err_pulse(evq[9]), .sig_valid(sig_valid), .sig_timeslot(sig_ts), .sig_abcd(sig_abcd),
    .signaling_irq(irq));
  // Clock and hang guard
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Address and data offered together, each dropped at its own ready
  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk(bresp, er);
        done = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask
  // Data checked only when an OKAY answer is expected
  task rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        chk(rresp, er);
        if (er === RESP_OKAY) chk(rdata, {24'h0, d});
        done = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask
  // One period of framer events, each source pulsed its own number of cycles
  task fire;
    for (int i = 0; i < 800; i++) begin
      @(posedge mclk);
      for (int k = 0; k < 10; k++) evq[k] <= (i < ecnt[k]);
    end
  endtask
  task sg(input logic [4:0] ts, input logic [3:0] abcd);
    @(posedge mclk);
    sig_valid <= 1'b1;
    sig_ts <= ts;
    sig_abcd <= abcd;
    @(posedge mclk);
    sig_valid <= 1'b0;
  endtask
  task end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Snapshots and flags read zero out of reset
  task t_reset_values;
    for (int i = 0; i < 16; i++) begin
      rd(8'(i), 8'h00, RESP_OKAY);
    end
    rd(IDX_SIG_FLAGS3, 8'h00, RESP_OKAY);
  endtask
  // Counts stay hidden until the trigger rises, then all refresh together
  task t_manual_snapshot;
    fire();
    rd(IDX_CRC_LO, 8'h00, RESP_OKAY);
    wr(IDX_SNAP_CTRL, 8'h02, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      rd(8'(i), exp1[i], RESP_OKAY);
    end
  endtask
  // HDB3 mode counts code violations only; live counts restarted
  task t_code_mode;
    wr(IDX_SNAP_CTRL, 8'h04, RESP_OKAY);
    fire();
    wr(IDX_SNAP_CTRL, 8'h06, RESP_OKAY);
    rd(IDX_VIOL_LO, 8'h44, RESP_OKAY);
    rd(IDX_VIOL_HI, 8'h00, RESP_OKAY);
    rd(IDX_CRC_LO, 8'hA5, RESP_OKAY);
  endtask
  // Counters ignore writes; unmapped indexes answer with an error
  task t_bus_errors;
    wr(IDX_CRC_LO, 8'hFF, RESP_OKAY);
    rd(IDX_CRC_LO, 8'hA5, RESP_OKAY);
    rd(8'h40, 8'h00, RESP_SLVERR);
    wr(8'h41, 8'h00, RESP_SLVERR);
  endtask
  // Steady events: each auto period holds exactly one second of counts
  task t_auto_snapshot;
    evq[0] <= 1'b1;
    wr(IDX_SNAP_CTRL, 8'h01, RESP_OKAY);
    repeat (1000) @(posedge mclk);
    rd(IDX_CRC_LO, 8'h2C, RESP_OKAY);
    rd(IDX_CRC_HI, 8'h10, RESP_OKAY);
    evq[0] <= 1'b0;
    wr(IDX_SNAP_CTRL, 8'h00, RESP_OKAY);
  endtask
  // Change flags: timeslot 25 is outside this register
  task t_change_flags;
    sg(5'h1A, 4'h5);
    sg(5'h1F, 4'h3);
    sg(5'h19, 4'hF);
    rd(IDX_SIG_FLAGS3, 8'h21, RESP_OKAY);
    chk(irq, 1'b0);
    wr(IDX_SIG_FLAGS3, 8'h01, RESP_OKAY);
    sg(5'h1A, 4'h5);
    rd(IDX_SIG_FLAGS3, 8'h20, RESP_OKAY);
    wr(IDX_SIG_CFG, 8'h02, RESP_OKAY);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    wr(IDX_SIG_FLAGS3, 8'hFF, RESP_OKAY);
    rd(IDX_SIG_FLAGS3, 8'h00, RESP_OKAY);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    t_reset_values();
    t_manual_snapshot();
    t_code_mode();
    t_bus_errors();
    t_auto_snapshot();
    t_change_flags();
    end_sim();
  end
endmodule
